// *** pkg/scpc_pkg.sv ***
`default_nettype none

// Shared constants for the serial configuration and pump control registers.
package scpc_pkg;

  // Register width on the internal register port.
  localparam int SCPC_DW = 8;

  // Register addresses on the internal register port.
  localparam logic [7:0] SCPC_ADDR_CFG       = 8'h00;
  localparam logic [7:0] SCPC_ADDR_RBSEL     = 8'h04;
  localparam logic [7:0] SCPC_ADDR_UPDATE    = 8'h05;
  localparam logic [7:0] SCPC_ADDR_PUMP_CODE = 8'h0A;
  localparam logic [7:0] SCPC_ADDR_PUMP_CTRL = 8'h0B;

  // Field positions in the serial port configuration register.
  localparam int SCPC_CFG_WIRE_BIT   = 7;
  localparam int SCPC_CFG_ORDER_BIT  = 6;
  localparam int SCPC_CFG_SRST_BIT   = 5;
  localparam int SCPC_CFG_MODE16_BIT = 4;

  // Values that the configuration register shows in its fixed bits, and the order bit after reset.
  localparam logic SCPC_CFG_WIRE_VAL   = 1'b0;
  localparam logic SCPC_CFG_MODE16_VAL = 1'b1;
  localparam logic SCPC_LSB_FIRST_RST  = 1'b0;

  // Readback select and commit strobe bit positions.
  localparam int   SCPC_RBSEL_BIT  = 0;
  localparam logic SCPC_RBSEL_RST  = 1'b0;
  localparam int   SCPC_UPDATE_BIT = 0;

  // Field positions in the pump and detector control register.
  localparam int SCPC_CTRL_CUR_EN_BIT   = 7;
  localparam int SCPC_CTRL_ABL_EN_BIT   = 6;
  localparam int SCPC_CTRL_MODE_HI      = 5;
  localparam int SCPC_CTRL_MODE_LO      = 4;
  localparam int SCPC_CTRL_MODE_EN_BIT  = 3;
  localparam int SCPC_CTRL_FB_EDGE_BIT  = 2;
  localparam int SCPC_CTRL_REF_EDGE_BIT = 1;
  localparam int SCPC_CTRL_VCO_MID_BIT  = 0;

  // Values after reset of the buffered registers.
  localparam logic [7:0] SCPC_PUMP_CODE_RST = 8'h80;
  localparam logic [7:0] SCPC_PUMP_CTRL_RST = 8'h30;

  // Buffered register count and their indices.
  localparam int SCPC_NBUF     = 2;
  localparam int SCPC_BUF_CODE = 0;
  localparam int SCPC_BUF_CTRL = 1;

  // Read answer for addresses outside this group.
  localparam logic [7:0] SCPC_RD_UNMAPPED = 8'h00;

  // Read answer latency in cycles, for reference by the bench.
  localparam int SCPC_RD_LATENCY = 1;

  // Charge pump drive mode encoding.
  typedef enum logic [1:0] {
    SCPC_PUMP_TRISTATE = 2'b00,
    SCPC_PUMP_UP       = 2'b01,
    SCPC_PUMP_DOWN     = 2'b10,
    SCPC_PUMP_NORMAL   = 2'b11
  } scpc_pump_mode_type;

endpackage

`default_nettype wire

// *** hw/scpc_buf_reg.sv ***
`default_nettype none

// One buffered register: a pending copy written by the host and an
// active copy that the device logic sees after a commit.
module scpc_buf_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  input  wire logic       commit,
  output logic      [7:0] shadow_reg,
  output logic      [7:0] active_reg
);

  // The pending copy takes every write; it has no effect on its own.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      shadow_reg <= RESET_VAL;
    end else if (wr_en) begin
      shadow_reg <= wdata;
    end
  end

  // commit copies pending.
  // The active copy moves only on a commit or a clear, so a half-written set of
  // fields never reaches the pump.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      active_reg <= RESET_VAL;
    end else if (commit) begin
      active_reg <= shadow_reg;
    end
  end

endmodule

`default_nettype wire

// *** hw/scpc_regs.sv ***
`default_nettype none

module scpc_regs (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         reg_wr_en,
  input  wire logic                         reg_rd_en,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [scpc_pkg::SCPC_DW-1:0] reg_wdata,
  input  wire logic [7:0]                   auto_pump_current,
  input  wire logic [1:0]                   auto_pump_mode,
  input  wire logic [1:0]                   auto_abl_period,
  input  wire logic [1:0]                   abl_field,
  output logic      [scpc_pkg::SCPC_DW-1:0] reg_rdata,
  output logic                              reg_rd_valid,
  output logic                              lsb_first,
  output logic      [7:0]                   pump_current,
  output logic      [1:0]                   pump_drive_mode,
  output logic      [1:0]                   abl_period,
  output logic                              fb_edge_falling,
  output logic                              ref_edge_falling,
  output logic                              vco_midscale_force
);
  import scpc_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Stored transfer order bit, the only stored bit of the configuration.
  logic       lsb_first_reg;
  // Readback source: zero reads the active copy, one the pending copy.
  logic       rbsel_reg;
  // One-cycle pulse that restores the stored and buffered registers after a soft reset write.
  logic       soft_rst_reg;
  // One-cycle pulse that moves pending values into the active copies.
  logic       commit_reg;
  // Clear seen by the stored and buffered registers: hardware reset or soft reset.
  logic       clear;
  // Configuration byte as it reads back, mirror included.
  logic [7:0] cfg_view;
  // Upper nibble of the configuration byte.
  logic [3:0] cfg_hi;
  // Read data selected for the current address.
  logic [7:0] rd_next;
  // Pending and active copies of the buffered registers.
  logic [7:0] shadow_q [SCPC_NBUF];
  logic [7:0] active_q [SCPC_NBUF];
  // Per-register write strobes for the buffered group.
  logic [SCPC_NBUF-1:0] buf_wr;
  // Active control byte, named for readability.
  logic [7:0] ctrl_act;
  // Next values of the applied outputs.
  logic [7:0] pump_current_next;
  logic [1:0] pump_mode_next;
  logic [1:0] abl_period_next;

  assign clear = sys_rst | soft_rst_reg;
  assign ctrl_act = active_q[SCPC_BUF_CTRL];

  // Write strobes for the two buffered registers.
  assign buf_wr[SCPC_BUF_CODE] = reg_wr_en && (reg_addr == SCPC_ADDR_PUMP_CODE);
  assign buf_wr[SCPC_BUF_CTRL] = reg_wr_en && (reg_addr == SCPC_ADDR_PUMP_CTRL);

  // The two buffered registers share one structure; only the value after
  // reset differs, so they are built from one loop.
  genvar gi;
  generate
    for (gi = 0; gi < SCPC_NBUF; gi++) begin : g_buf
      scpc_buf_reg #(
        .RESET_VAL (gi == SCPC_BUF_CODE ? SCPC_PUMP_CODE_RST : SCPC_PUMP_CTRL_RST)
      ) u_buf (
        .core_clk   (core_clk),
        .clear      (clear),
        .wr_en      (buf_wr[gi]),
        .wdata      (reg_wdata),
        .commit     (commit_reg),
        .shadow_reg (shadow_q[gi]),
        .active_reg (active_q[gi])
      );
    end
  endgenerate

  // Transfer order bit. A soft reset write also restores it, since the
  // reset pulse in the next cycle overrides whatever was written.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      lsb_first_reg <= SCPC_LSB_FIRST_RST;
    end else if (reg_wr_en && reg_addr == SCPC_ADDR_CFG) begin
      lsb_first_reg <= reg_wdata[SCPC_CFG_ORDER_BIT];
    end
  end

  // Soft reset pulse. It is never stored as a readable bit, so the bit
  // clears itself and reads back as zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= reg_wr_en && (reg_addr == SCPC_ADDR_CFG)
                      && reg_wdata[SCPC_CFG_SRST_BIT];
    end
  end

  // Readback select; only bit 0 is kept, the rest of the byte is dropped.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      rbsel_reg <= SCPC_RBSEL_RST;
    end else if (reg_wr_en && reg_addr == SCPC_ADDR_RBSEL) begin
      rbsel_reg <= reg_wdata[SCPC_RBSEL_BIT];
    end
  end

  // Commit strobe pulse. It lasts one cycle and is never readable.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= reg_wr_en && (reg_addr == SCPC_ADDR_UPDATE)
                    && reg_wdata[SCPC_UPDATE_BIT];
    end
  end

  // Configuration view: the fixed bits are forced, never stored.
  always_comb begin
    cfg_hi = 4'h0;
    cfg_hi[SCPC_CFG_WIRE_BIT-4] = SCPC_CFG_WIRE_VAL;
    cfg_hi[SCPC_CFG_ORDER_BIT-4] = lsb_first_reg;
    cfg_hi[SCPC_CFG_SRST_BIT-4] = 1'b0;
    cfg_hi[SCPC_CFG_MODE16_BIT-4] = SCPC_CFG_MODE16_VAL;
    cfg_view = {cfg_hi, cfg_hi};
  end

  // Read data select. Buffered registers answer from the copy that the
  // readback select names; unmapped addresses answer zero.
  always_comb begin
    if (reg_addr == SCPC_ADDR_CFG) begin
      rd_next = cfg_view;
    end else if (reg_addr == SCPC_ADDR_RBSEL) begin
      rd_next = {7'h00, rbsel_reg};
    end else if (reg_addr == SCPC_ADDR_UPDATE) begin
      rd_next = 8'h00;
    end else if (reg_addr == SCPC_ADDR_PUMP_CODE) begin
      rd_next = rbsel_reg ? shadow_q[SCPC_BUF_CODE] : active_q[SCPC_BUF_CODE];
    end else if (reg_addr == SCPC_ADDR_PUMP_CTRL) begin
      rd_next = rbsel_reg ? shadow_q[SCPC_BUF_CTRL] : active_q[SCPC_BUF_CTRL];
    end else begin
      rd_next = SCPC_RD_UNMAPPED;
    end
  end

  // Read answer register: data and valid one cycle after the request.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rd_next;
      end
    end
  end

  // Selection between the device's own choice and the programmed value.
  // All enables are active high.
  always_comb begin
    pump_current_next = ctrl_act[SCPC_CTRL_CUR_EN_BIT] ? active_q[SCPC_BUF_CODE]
                                                       : auto_pump_current;
    pump_mode_next = ctrl_act[SCPC_CTRL_MODE_EN_BIT]
                     ? ctrl_act[SCPC_CTRL_MODE_HI:SCPC_CTRL_MODE_LO]
                     : auto_pump_mode;
    abl_period_next = ctrl_act[SCPC_CTRL_ABL_EN_BIT] ? abl_field : auto_abl_period;
  end

  // Applied control outputs, all registered so the analog side sees clean
  // levels; they lag the active copy and the stored order bit by one cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lsb_first          <= SCPC_LSB_FIRST_RST;
      pump_current       <= SCPC_PUMP_CODE_RST;
      pump_drive_mode    <= SCPC_PUMP_NORMAL;
      abl_period         <= 2'b00;
      fb_edge_falling    <= 1'b0;
      ref_edge_falling   <= 1'b0;
      vco_midscale_force <= 1'b0;
    end else begin
      lsb_first          <= lsb_first_reg;
      pump_current       <= pump_current_next;
      pump_drive_mode    <= pump_mode_next;
      abl_period         <= abl_period_next;
      fb_edge_falling    <= ctrl_act[SCPC_CTRL_FB_EDGE_BIT];
      ref_edge_falling   <= ctrl_act[SCPC_CTRL_REF_EDGE_BIT];
      vco_midscale_force <= ctrl_act[SCPC_CTRL_VCO_MID_BIT];
    end
  end

  // Checks on the read answers of the configuration byte.
  cfg_top_zero_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_CFG) |-> reg_rdata[7] == 1'b0)
    else $error("Configuration bit 7 read as one.");

  cfg_order_rd_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_CFG) |-> reg_rdata[6] == $past(lsb_first_reg))
    else $error("Order bit readback differs from stored bit.");

  cfg_mode16_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_CFG) |-> reg_rdata[4] == 1'b1)
    else $error("Configuration bit 4 read as zero.");

  cfg_mirror_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_CFG) |-> reg_rdata[3:0] == reg_rdata[7:4])
    else $error("Configuration low nibble not a mirror.");

  // A soft reset write restores the code and order bit two edges later.
  soft_rst_dflt_a : assert property (
    (reg_wr_en && reg_addr == SCPC_ADDR_CFG && reg_wdata[5]) |-> ##2
      (active_q[SCPC_BUF_CODE] == SCPC_PUMP_CODE_RST && !lsb_first_reg && !soft_rst_reg))
    else $error("Soft reset did not restore defaults.");

  readback_src_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_PUMP_CODE) |->
      reg_rdata == ($past(rbsel_reg) ? $past(shadow_q[SCPC_BUF_CODE])
                                     : $past(active_q[SCPC_BUF_CODE])))
    else $error("Buffered readback from wrong copy.");

  pending_hold_a : assert property (
    (!commit_reg && !soft_rst_reg) |=> $stable(active_q[SCPC_BUF_CTRL]))
    else $error("Active control changed without a commit.");

  // A commit that lands on a soft reset pulse is dropped: the reset wins.
  commit_copy_a : assert property (
    (reg_wr_en && reg_addr == SCPC_ADDR_UPDATE && reg_wdata[0] && !soft_rst_reg)
      |=> commit_reg ##1
      (active_q[SCPC_BUF_CODE] == $past(shadow_q[SCPC_BUF_CODE]) && !commit_reg))
    else $error("Commit did not copy pending value.");

  current_sel_a : assert property (
    1'b1 |=> pump_current == ($past(ctrl_act[7]) ? $past(active_q[SCPC_BUF_CODE])
                                                 : $past(auto_pump_current)))
    else $error("Applied pump current from wrong source.");

  mode_sel_a : assert property (
    1'b1 |=> pump_drive_mode == ($past(ctrl_act[3]) ? $past(ctrl_act[5:4])
                                                    : $past(auto_pump_mode)))
    else $error("Applied pump mode from wrong source.");

  // The antibacklash period follows its manual enable like the other fields.
  abl_sel_a : assert property (
    1'b1 |=> abl_period == ($past(ctrl_act[SCPC_CTRL_ABL_EN_BIT]) ? $past(abl_field)
                                                                 : $past(auto_abl_period)))
    else $error("Applied antibacklash period from wrong source.");

  // The edge selects and the midscale force copy the active control bits.
  fb_edge_a : assert property (
    1'b1 |=> fb_edge_falling == $past(ctrl_act[SCPC_CTRL_FB_EDGE_BIT]))
    else $error("Feedback edge select differs from active bit.");

  ref_edge_a : assert property (
    1'b1 |=> ref_edge_falling == $past(ctrl_act[SCPC_CTRL_REF_EDGE_BIT]))
    else $error("Reference edge select differs from active bit.");

  vco_mid_a : assert property (
    1'b1 |=> vco_midscale_force == $past(ctrl_act[SCPC_CTRL_VCO_MID_BIT]))
    else $error("Midscale force differs from active bit.");

  // Every read gets exactly one answer pulse, one edge later.
  rd_answer_a : assert property (
    1'b1 |=> reg_rd_valid == $past(reg_rd_en))
    else $error("Read answer pulse without a matching read.");

  // The select register shows only its one stored bit.
  rbsel_unused_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_RBSEL) |-> reg_rdata[7:1] == 7'h00)
    else $error("Unused readback select bits read as one.");

  // The commit strobe is never stored, so its register reads zero.
  update_rd_a : assert property (
    $past(reg_rd_en && reg_addr == SCPC_ADDR_UPDATE) |-> reg_rdata == 8'h00)
    else $error("Commit strobe register read nonzero.");

endmodule

`default_nettype wire

// *** sim/scpc_host.sv ***
`default_nettype none

// Host model: stands where the serial engine hands finished accesses over.
module scpc_host (
  input  wire logic       core_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Lines start quiet before the first edge.
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one whole byte per access
  // A request is held through its taking edge; no strobe drops between calls.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_rd_en = 1'b0;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
  endtask

  // A read leaves the data lines flipping so stale data is never mistaken.
  task automatic rd(input logic [7:0] a);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    reg_addr  = a;
    reg_wdata = ~reg_wdata;
    @(posedge core_clk);
    #1;
  endtask

  // Released lines show a changing pattern rather than the last value.
  task automatic idle(input int n);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    repeat (n) begin
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule

`default_nettype wire

// *** sim/scpc_regs_tb.sv ***
`default_nettype none

// Bench: a plain model of the register group is compared at every result.
module scpc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scpc_pkg::*;

  logic       core_clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, lsb_first;
  logic       fb_edge_falling, ref_edge_falling, vco_midscale_force;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, auto_pump_current, pump_current;
  logic [1:0] auto_pump_mode, auto_abl_period, abl_field, pump_drive_mode, abl_period;
  // Model state: pending and active copies, order bit and readback select.
  logic [7:0] m_code_sh, m_ctrl_sh, m_code_ac, m_ctrl_ac;
  logic       m_lsb, m_sel;
  logic [31:0] d;
  logic [31:0] seed = 32'hAA9F;
  int         n_errors = 0;
  int         comparisons = 0;

  scpc_host host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  scpc_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .auto_pump_current(auto_pump_current), .auto_pump_mode(auto_pump_mode),
    .auto_abl_period(auto_abl_period), .abl_field(abl_field), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .lsb_first(lsb_first), .pump_current(pump_current),
    .pump_drive_mode(pump_drive_mode), .abl_period(abl_period),
    .fb_edge_falling(fb_edge_falling), .ref_edge_falling(ref_edge_falling),
    .vco_midscale_force(vco_midscale_force));

  initial core_clk = 1'b0;
  // A 25 ns period gives the 40 MHz core rate.
  always #12.5 core_clk = ~core_clk;

  // Xorshift keeps the random stream repeatable run to run.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Defaults after a hard or soft reset.
  task automatic model_rst();
    m_code_sh = 8'h80;
    m_code_ac = 8'h80;
    m_ctrl_sh = 8'h30;
    m_ctrl_ac = 8'h30;
    m_lsb = 1'b0;
    m_sel = 1'b0;
  endtask

  // Outputs while reset is held: code 0x80, normal pump mode, all else low.
  task automatic rst_chk();
    chk(pump_current, 8'h80);
    chk({4'h0, pump_drive_mode, abl_period}, 8'h0C);
    chk({5'h00, fb_edge_falling, ref_edge_falling, vco_midscale_force}, 8'h00);
  endtask

  // A write through the host, mirrored in the model.
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v);
    if (a == SCPC_ADDR_CFG && v[5]) model_rst();
    else if (a == SCPC_ADDR_CFG) m_lsb = v[6];
    if (a == SCPC_ADDR_RBSEL) m_sel = v[0];
    if (a == SCPC_ADDR_PUMP_CODE) m_code_sh = v;
    if (a == SCPC_ADDR_PUMP_CTRL) m_ctrl_sh = v;
    if (a == SCPC_ADDR_UPDATE && v[0]) begin
      m_code_ac = m_code_sh;
      m_ctrl_ac = m_ctrl_sh;
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      SCPC_ADDR_CFG:       return {1'b0, m_lsb, 2'b01, 1'b0, m_lsb, 2'b01};
      SCPC_ADDR_RBSEL:     return {7'h00, m_sel};
      SCPC_ADDR_PUMP_CODE: return m_sel ? m_code_sh : m_code_ac;
      SCPC_ADDR_PUMP_CTRL: return m_sel ? m_ctrl_sh : m_ctrl_ac;
      default:             return 8'h00;
    endcase
  endfunction

  // A read answers one edge after it is taken.
  task automatic r(input logic [7:0] a);
    host.rd(a);
    chk({7'h00, reg_rd_valid}, 8'h01);
    chk(reg_rdata, exp_rd(a));
  endtask

  // Four idle edges cover the commit path before outputs are compared.
  task automatic settle();
    host.idle(4);
    chk({7'h00, reg_rd_valid}, 8'h00);
    chk({7'h00, lsb_first}, {7'h00, m_lsb});
    chk(pump_current, m_ctrl_ac[7] ? m_code_ac : auto_pump_current);
    chk({6'h00, pump_drive_mode}, {6'h00, m_ctrl_ac[3] ? m_ctrl_ac[5:4] : auto_pump_mode});
    chk({6'h00, abl_period}, {6'h00, m_ctrl_ac[6] ? abl_field : auto_abl_period});
    chk({5'h00, fb_edge_falling, ref_edge_falling, vco_midscale_force},
        {5'h00, m_ctrl_ac[2:0]});
  endtask

  // Fresh random values for everything the device chooses by itself.
  task automatic new_auto();
    d = xs();
    auto_pump_current = d[7:0];
    auto_pump_mode = d[9:8];
    auto_abl_period = d[11:10];
    abl_field = d[13:12];
  endtask

  // Watchdog sized well above the expected run of about six hundred cycles.
  initial begin
    #(25 * 40000);
    n_errors++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    new_auto();
    model_rst();
    repeat (6) @(posedge core_clk);
    #1;
    rst_chk();
    sys_rst = 1'b0;
    settle();
    r(SCPC_ADDR_PUMP_CODE);
    r(SCPC_ADDR_PUMP_CTRL);
    r(SCPC_ADDR_CFG);
    r(SCPC_ADDR_UPDATE);
    r(8'h07);
    // Fixed config bits ignore writes; order bit flips the output.
    w(SCPC_ADDR_CFG, 8'hDF);
    r(SCPC_ADDR_CFG);
    settle();
    w(SCPC_ADDR_CFG, 8'h00);
    w(SCPC_ADDR_RBSEL, 8'hFE);
    w(SCPC_ADDR_UPDATE, 8'hFE);
    w(8'h07, 8'hFF);
    r(SCPC_ADDR_RBSEL);
    // Pending writes stay invisible until the commit.
    new_auto();
    w(SCPC_ADDR_PUMP_CODE, 8'h3C);
    w(SCPC_ADDR_PUMP_CTRL, 8'hFF);
    settle();
    w(SCPC_ADDR_RBSEL, 8'h01);
    r(SCPC_ADDR_PUMP_CODE);
    r(SCPC_ADDR_PUMP_CTRL);
    w(SCPC_ADDR_RBSEL, 8'h00);
    r(SCPC_ADDR_PUMP_CODE);
    w(SCPC_ADDR_PUMP_CODE, 8'h5A);
    w(SCPC_ADDR_UPDATE, 8'h01);
    settle();
    r(SCPC_ADDR_UPDATE);
    // Every drive mode, automatic then programmed.
    for (int i = 0; i < 8; i++) begin
      w(SCPC_ADDR_PUMP_CTRL, {2'b00, i[1:0], i[2], 3'b000});
      w(SCPC_ADDR_UPDATE, 8'h01);
      settle();
    end
    // Soft reset lands on a pending value and a following commit.
    w(SCPC_ADDR_PUMP_CODE, 8'h11);
    w(SCPC_ADDR_CFG, 8'h60);
    w(SCPC_ADDR_UPDATE, 8'h01);
    settle();
    r(SCPC_ADDR_PUMP_CODE);
    r(SCPC_ADDR_CFG);
    // Random control values with and without a commit.
    for (int i = 0; i < 60; i++) begin
      new_auto();
      w(d[16] ? SCPC_ADDR_PUMP_CTRL : SCPC_ADDR_PUMP_CODE, d[31:24]);
      w(SCPC_ADDR_UPDATE, {7'h00, d[17]});
      w(SCPC_ADDR_RBSEL, {7'h00, d[18]});
      settle();
      r(SCPC_ADDR_PUMP_CTRL);
    end
    // A second hard reset in mid-run.
    sys_rst = 1'b1;
    host.idle(2);
    rst_chk();
    sys_rst = 1'b0;
    model_rst();
    settle();
    give_verdict();
  end
endmodule

`default_nettype wire
